// *** core/dmrz_core.v ***
// Mode register zero of a DDR3 memory device and the burst logic it steers.
`timescale 1ns/1ps
`include "dmrz_map.vh"

module dmrz_core (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_cke,
  input wire i_cs_n,
  input wire i_ras_n,
  input wire i_cas_n,
  input wire i_we_n,
  input wire [2:0] i_ba,
  input wire [15:0] i_addr,
  output reg [18:0] o_mode_ff,
  output reg [3:0] o_cas_lat_ff,
  output reg [3:0] o_wr_rec_ff,
  output reg o_cfg_err_ff,
  output reg o_dll_ppd_on_ff,
  output reg o_dll_reset_ff,
  output reg o_dll_locked_ff,
  output reg o_int_start_ff,
  output reg o_beat_vld_ff,
  output reg o_beat_wr_ff,
  output reg o_dq_oe_ff,
  output reg [2:0] o_col_ff,
  output reg o_busy_ff
);

  // --------------------------------------------------------------------
  // Burst states
  // --------------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_WAIT = 3'h2;
  localparam [2:0] ST_BURST = 3'h4;

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  // The command pins come from the controller's domain, so each passes
  // two flops; only the second stage is decoded.
  reg [23:0] pin_s1_ff;
  reg [23:0] pin_s2_ff;
  wire [23:0] pin_raw;

  assign pin_raw = {i_cke, i_cs_n, i_ras_n, i_cas_n, i_we_n, i_ba, i_addr};

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_s1_ff <= 24'h000000;
      pin_s2_ff <= 24'h000000;
    end else begin
      pin_s1_ff <= pin_raw;
      pin_s2_ff <= pin_s1_ff;
    end
  end

  // --------------------------------------------------------------------
  // Command decode
  // --------------------------------------------------------------------
  // A command only counts while clock enable is sampled high.
  wire cke_s;
  wire [3:0] cmd_s;
  wire [2:0] ba_s;
  wire [15:0] addr_s;
  wire is_mrs;
  wire is_rd;
  wire is_wr;

  assign cke_s = pin_s2_ff[23];
  assign cmd_s = pin_s2_ff[22:19];
  assign ba_s = pin_s2_ff[18:16];
  assign addr_s = pin_s2_ff[15:0];
  assign is_mrs = cke_s && (cmd_s == `DMRZ_CMD_MRS) && (ba_s == `DMRZ_BA_BASE);
  assign is_rd = cke_s && (cmd_s == `DMRZ_CMD_RD);
  assign is_wr = cke_s && (cmd_s == `DMRZ_CMD_WR);

  // --------------------------------------------------------------------
  // Field decoders
  // --------------------------------------------------------------------
  // CAS latency code is {A6:A4, A2}; unlisted codes report zero cycles
  // and raise the error flag rather than guessing a latency.
  function [3:0] dmrz_cl_dec;
    input [3:0] code;
    begin
      case (code)
        4'h2: dmrz_cl_dec = 4'h5;
        4'h4: dmrz_cl_dec = 4'h6;
        4'h6: dmrz_cl_dec = 4'h7;
        4'h8: dmrz_cl_dec = 4'h8;
        4'ha: dmrz_cl_dec = 4'h9;
        4'hc: dmrz_cl_dec = 4'ha;
        4'he: dmrz_cl_dec = 4'hb;
        4'h1: dmrz_cl_dec = 4'hc;
        4'h3: dmrz_cl_dec = 4'hd;
        4'h5: dmrz_cl_dec = 4'he;
        default: dmrz_cl_dec = 4'h0;
      endcase
    end
  endfunction

  // Write recovery supports 5, 6, 7, 8, 10 and 12 cycles only.
  function [3:0] dmrz_wr_dec;
    input [2:0] code;
    begin
      case (code)
        3'h1: dmrz_wr_dec = 4'h5;
        3'h2: dmrz_wr_dec = 4'h6;
        3'h3: dmrz_wr_dec = 4'h7;
        3'h4: dmrz_wr_dec = 4'h8;
        3'h5: dmrz_wr_dec = 4'ha;
        3'h6: dmrz_wr_dec = 4'hc;
        default: dmrz_wr_dec = 4'h0;
      endcase
    end
  endfunction

  // Column of beat idx. Reads keep the block and wrap inside the nibble;
  // writes start on a nibble boundary and always count upward.
  function [2:0] dmrz_col;
    input [2:0] st;
    input [2:0] idx;
    input ilv;
    input wr;
    input chop;
    reg [1:0] low;
    begin
      low = st[1:0] + idx[1:0];
      if (wr) begin
        dmrz_col = {(chop & st[2]) ^ idx[2], idx[1:0]};
      end else if (ilv) begin
        dmrz_col = st ^ idx;
      end else begin
        dmrz_col = {st[2] ^ idx[2], low};
      end
    end
  endfunction

  wire [18:0] mr_new;
  wire [3:0] cl_new;
  wire [3:0] wr_new;
  wire err_new;

  // Register image is {BA2:BA0, A15:A0}.
  assign mr_new = {ba_s, addr_s};
  assign cl_new = dmrz_cl_dec({mr_new[`DMRZ_CL_HI:`DMRZ_CL_LO], mr_new[`DMRZ_CL_B0]});
  assign wr_new = dmrz_wr_dec(mr_new[`DMRZ_WR_HI:`DMRZ_WR_LO]);
  assign err_new = (cl_new == 4'h0) || (wr_new == 4'h0) ||
                   (mr_new[`DMRZ_BL_HI:`DMRZ_BL_LO] == 2'h3) ||
                   ((mr_new & `DMRZ_RSV_MASK) != 19'h00000);

  // --------------------------------------------------------------------
  // Mode register and DLL reset
  // --------------------------------------------------------------------
  // A load is accepted only while no burst runs, so a burst never sees
  // its settings change midway. The DLL reset bit drops one cycle after
  // it is written, which is the cycle the reset pulse goes out.
  reg [9:0] dllk_cnt_ff;

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_mode_ff <= `DMRZ_MR_RST;
      o_cas_lat_ff <= 4'h0;
      o_wr_rec_ff <= 4'h0;
      o_cfg_err_ff <= 1'b0;
      o_dll_ppd_on_ff <= 1'b0;
      o_dll_reset_ff <= 1'b0;
    end else begin
      o_dll_reset_ff <= o_mode_ff[`DMRZ_DLLR_BIT];
      if (is_mrs && o_busy_ff == 1'b0) begin
        o_mode_ff <= mr_new;
        o_cas_lat_ff <= cl_new;
        o_wr_rec_ff <= wr_new;
        o_cfg_err_ff <= err_new;
        o_dll_ppd_on_ff <= mr_new[`DMRZ_PPD_BIT];
      end else begin
        o_mode_ff[`DMRZ_DLLR_BIT] <= 1'b0;
      end
    end
  end

  // Lock counter after a DLL reset; the controller keeps the clock
  // steady meanwhile, the device only reports when lock is reached.
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dllk_cnt_ff <= 10'h000;
      o_dll_locked_ff <= 1'b0;
    end else if (o_dll_reset_ff) begin
      dllk_cnt_ff <= `DMRZ_DLLK_CYC;
      o_dll_locked_ff <= 1'b0;
    end else if (dllk_cnt_ff != 10'h000) begin
      dllk_cnt_ff <= dllk_cnt_ff - 10'h001;
      o_dll_locked_ff <= (dllk_cnt_ff == 10'h001);
    end
  end

  // --------------------------------------------------------------------
  // Burst chop selection
  // --------------------------------------------------------------------
  // One setting serves reads and writes alike; the on-the-fly code
  // defers the choice to address bit 12 of each command.
  wire [1:0] bl_fld;
  reg chop_sel;

  assign bl_fld = o_mode_ff[`DMRZ_BL_HI:`DMRZ_BL_LO];

  always @* begin
    chop_sel = 1'b0;
    if (bl_fld == `DMRZ_BL_BC4) begin
      chop_sel = 1'b1;
    end else if (bl_fld == `DMRZ_BL_OTF) begin
      chop_sel = ~addr_s[`DMRZ_OTF_BIT];
    end
  end

  // --------------------------------------------------------------------
  // Burst sequencer
  // --------------------------------------------------------------------
  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [3:0] lat_cnt_ff;
  reg [3:0] nxt_lat_cnt;
  reg [2:0] beat_ff;
  reg [2:0] nxt_beat;
  reg [2:0] start_ff;
  reg [2:0] nxt_start;
  reg chop_ff;
  reg nxt_chop;
  reg wr_ff;
  reg nxt_wr;
  reg ilv_ff;
  reg nxt_ilv;
  reg go;
  wire cmd_take;

  // Commands arriving during a burst are ignored by design.
  assign cmd_take = (is_rd || is_wr) && (state_ff == ST_IDLE);

  always @* begin
    nxt_state = state_ff;
    nxt_lat_cnt = lat_cnt_ff;
    nxt_beat = beat_ff;
    nxt_start = start_ff;
    nxt_chop = chop_ff;
    nxt_wr = wr_ff;
    nxt_ilv = ilv_ff;
    go = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (cmd_take) begin
          nxt_start = addr_s[2:0];
          nxt_chop = chop_sel;
          nxt_wr = is_wr;
          nxt_ilv = o_mode_ff[`DMRZ_BT_BIT];
          // Latency counts from the edge that registers the command.
          nxt_lat_cnt = is_wr ? `DMRZ_WR_LAT : o_cas_lat_ff;
          nxt_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // Leaving on a count of one puts the first beat n edges after, n being the loaded count,
        // the command edge; a reserved latency of zero leaves at once.
        nxt_lat_cnt = lat_cnt_ff - 4'h1;
        if (lat_cnt_ff <= 4'h1) begin
          go = 1'b1;
        end
      end
      ST_BURST: begin
        nxt_beat = beat_ff + 3'h1;
        // A chopped burst still takes all eight slots.
        if (beat_ff == `DMRZ_LAST_BEAT) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    if (go) begin
      nxt_state = ST_BURST;
      nxt_beat = 3'h0;
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= ST_IDLE;
      lat_cnt_ff <= 4'h0;
      beat_ff <= 3'h0;
      start_ff <= 3'h0;
      chop_ff <= 1'b0;
      wr_ff <= 1'b0;
      ilv_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      lat_cnt_ff <= nxt_lat_cnt;
      beat_ff <= nxt_beat;
      start_ff <= nxt_start;
      chop_ff <= nxt_chop;
      wr_ff <= nxt_wr;
      ilv_ff <= nxt_ilv;
    end
  end

  // --------------------------------------------------------------------
  // Beat outputs
  // --------------------------------------------------------------------
  // Outputs show the beat the sequencer enters, so they line up with
  // the state register one edge at a time.
  wire in_burst;
  wire beat_live;

  assign in_burst = (nxt_state == ST_BURST);
  assign beat_live = in_burst && !(nxt_chop && nxt_beat > `DMRZ_CHOP_LAST);

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_int_start_ff <= 1'b0;
      o_beat_vld_ff <= 1'b0;
      o_beat_wr_ff <= 1'b0;
      o_dq_oe_ff <= 1'b0;
      o_col_ff <= 3'h0;
      o_busy_ff <= 1'b0;
    end else begin
      o_int_start_ff <= cmd_take;
      o_beat_vld_ff <= beat_live;
      o_beat_wr_ff <= beat_live && nxt_wr;
      // Drivers stay off in the idle slots of a chopped read.
      o_dq_oe_ff <= beat_live && !nxt_wr;
      o_col_ff <= beat_live ?
                  dmrz_col(nxt_start, nxt_beat, nxt_ilv, nxt_wr, nxt_chop) : 3'h0;
      o_busy_ff <= (nxt_state != ST_IDLE);
    end
  end

endmodule

// *** core/dmrz_map.vh ***
// Constants for the mode register zero decoder: fields, codes and timing.
`ifndef DMRZ_MAP_VH
`define DMRZ_MAP_VH

// ----------------------------------------------------------------------
// Register fields
// ----------------------------------------------------------------------
`define DMRZ_MR_W 19
`define DMRZ_MR_RST 19'h00000
`define DMRZ_BL_HI 1
`define DMRZ_BL_LO 0
`define DMRZ_CL_B0 2
`define DMRZ_BT_BIT 3
`define DMRZ_CL_HI 6
`define DMRZ_CL_LO 4
`define DMRZ_DLLR_BIT 8
`define DMRZ_WR_HI 11
`define DMRZ_WR_LO 9
`define DMRZ_PPD_BIT 12
`define DMRZ_OTF_BIT 12
`define DMRZ_RSV_MASK 19'h4e080

// ----------------------------------------------------------------------
// Field codes
// ----------------------------------------------------------------------
`define DMRZ_BL_FIX8 2'h0
`define DMRZ_BL_OTF 2'h1
`define DMRZ_BL_BC4 2'h2
`define DMRZ_BT_SEQ 1'h0
`define DMRZ_BT_ILV 1'h1

// ----------------------------------------------------------------------
// Command codes on {cs_n, ras_n, cas_n, we_n} and bank of this register
// ----------------------------------------------------------------------
`define DMRZ_CMD_MRS 4'h0
`define DMRZ_CMD_RD 4'h5
`define DMRZ_CMD_WR 4'h4
`define DMRZ_BA_BASE 3'h0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define DMRZ_DLLK_CYC 10'h200
`define DMRZ_WR_LAT 4'h1
`define DMRZ_LAST_BEAT 3'h7
`define DMRZ_CHOP_LAST 3'h3

`endif

// *** tb/dmrz_properties.sv ***
// Port assertions for the mode register zero decoder.
`timescale 1ns/1ps

module dmrz_properties (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_cs_n,
  input wire i_ras_n,
  input wire i_cas_n,
  input wire i_we_n,
  input wire [2:0] i_ba,
  input wire [18:0] o_mode_ff,
  input wire [3:0] o_cas_lat_ff,
  input wire [3:0] o_wr_rec_ff,
  input wire o_dll_ppd_on_ff,
  input wire o_dll_reset_ff,
  input wire o_dll_locked_ff,
  input wire o_int_start_ff,
  input wire o_beat_vld_ff,
  input wire o_beat_wr_ff,
  input wire o_dq_oe_ff,
  input wire [2:0] o_col_ff
);
  // ----------------------------------------------------------------
  // Decoding and checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // Latency code: A2 low gives 5 to 11, A2 high gives 12 to 14, the rest reserved.
  function automatic [3:0] cl_of(input [3:0] c);
    cl_of = c[0] ? ((c[3:1] > 3'h2) ? 4'h0 : 4'hc + c[3:1])
                 : ((c[3:1] == 3'h0) ? 4'h0 : 4'h4 + c[3:1]);
  endfunction

  // Recovery code: 9 and 11 cycles do not exist, so the top codes double.
  function automatic [3:0] wr_of(input [2:0] w);
    wr_of = (w == 3'h0 || w == 3'h7) ? 4'h0 : (w < 3'h5) ? w + 4'h4 : {w, 1'b0};
  endfunction

  AST_CAS_LAT: assert property (o_cas_lat_ff == cl_of({o_mode_ff[6:4], o_mode_ff[2]}))
    else $error("cas latency does not match mode image");
  AST_WR_REC: assert property (o_wr_rec_ff == wr_of(o_mode_ff[11:9]))
    else $error("write recovery does not match mode image");
  AST_PPD: assert property (o_dll_ppd_on_ff == o_mode_ff[12])
    else $error("power-down dll flag differs from bit 12");
  AST_DLL_CLR: assert property (o_mode_ff[8] |=> !o_mode_ff[8] && o_dll_reset_ff)
    else $error("dll reset bit did not clear with a pulse");
  AST_DLL_PULSE: assert property (o_dll_reset_ff |=> (!o_dll_reset_ff && !o_dll_locked_ff) [*8])
    else $error("dll reset pulse too long or lock kept");
  AST_MODE_HOLD: assert property ({o_mode_ff[18:9], o_mode_ff[7:0]}
    != $past({o_mode_ff[18:9], o_mode_ff[7:0]})
    |-> $past({i_cs_n, i_ras_n, i_cas_n, i_we_n, i_ba} == 7'h0, 3))
    else $error("mode image changed without a load");
  AST_OE_READ: assert property (o_dq_oe_ff |-> o_beat_vld_ff && !o_beat_wr_ff)
    else $error("drivers on outside a read beat");
  AST_IDLE_COL: assert property (!o_beat_vld_ff |-> o_col_ff == 3'h0 && !o_dq_oe_ff)
    else $error("idle slot shows a column or drives data");
  AST_WR_LAT: assert property (o_int_start_ff && $past(!i_we_n, 3)
    |=> o_beat_vld_ff && o_beat_wr_ff)
    else $error("write beat not one cycle after start");
  AST_START: assert property (o_int_start_ff |=> !o_int_start_ff)
    else $error("start pulse longer than one cycle");

  COV_DLL: cover property (o_dll_reset_ff);
  COV_READ: cover property (o_dq_oe_ff);
  COV_WRITE: cover property (o_beat_wr_ff);
endmodule

bind dmrz_core dmrz_properties u_props (.*);

// *** tb/dmrz_ctrl_model.sv ***
// Behavioural memory controller that loads mode register zero and issues bursts.
`timescale 1ns/1ps

module dmrz_ctrl_model (
  input wire i_clk,
  input wire i_busy,
  input wire i_locked,
  output reg o_cke,
  output reg o_cs_n,
  output reg o_ras_n,
  output reg o_cas_n,
  output reg o_we_n,
  output reg [2:0] o_ba,
  output reg [15:0] o_addr
);
  // ----------------------------------------------------------------
  // Command issue
  // ----------------------------------------------------------------
  parameter integer TMOD = 12;
  reg dll_pend = 1'b0;

  // Clock enable stays low until the first command, as after power-up.
  initial begin
    {o_cke, o_cs_n, o_ras_n, o_cas_n, o_we_n} = 5'h0f;
    o_ba = 3'h0;
    o_addr = 16'h0;
  end

  // One command, then deselect with the bus turned over so stale values never look valid.
  task automatic cmd(input [3:0] c, input [15:0] a);
    integer k;
    begin
      while (c == 4'h5 && dll_pend && !i_locked) @(posedge i_clk);
      if (!o_cke) begin
        o_cke <= 1'b1;
        repeat (5) @(posedge i_clk);
      end
      @(posedge i_clk);
      {o_cs_n, o_ras_n, o_cas_n, o_we_n} <= c;
      o_ba <= 3'h0;
      o_addr <= (c == 4'h0) ? (a & 16'h1f7f) : a;
      @(posedge i_clk);
      {o_cs_n, o_ras_n, o_cas_n, o_we_n} <= 4'hf;
      o_addr <= ~a;
      if (c == 4'h0) dll_pend = a[8];
      for (k = 0; k < TMOD; k = k + 1) @(posedge i_clk);
      while (i_busy) @(posedge i_clk);
    end
  endtask
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench for the mode register zero decoder.
`timescale 1ns/1ps

module tb_top;
  // ----------------------------------------------------------------
  // Bench
  // ----------------------------------------------------------------
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  wire cke, cs_n, ras_n, cas_n, we_n;
  wire [2:0] ba;
  wire [15:0] addr;
  wire [18:0] mode;
  wire [3:0] cl_o, wr_o;
  wire err, ppd, dll_rst, locked, start, vld, bwr, oe, busy;
  wire [2:0] col;
  integer num_errors = 0;
  integer n_checks = 0;
  integer cyc = 0;
  integer cnt = 0;
  integer t, k, i, cl, wr, m, twr_ns;
  reg first = 1'b0;
  reg chop, bt;
  reg [2:0] st;
  reg [15:0] a;
  reg [2:0] exp_col[$];
  reg exp_wr[$];
  integer exp_lat[$];

  dmrz_core dut (.i_clk(clk), .i_rst_n(rst_n), .i_cke(cke), .i_cs_n(cs_n),
    .i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n), .i_ba(ba), .i_addr(addr),
    .o_mode_ff(mode), .o_cas_lat_ff(cl_o), .o_wr_rec_ff(wr_o), .o_cfg_err_ff(err),
    .o_dll_ppd_on_ff(ppd), .o_dll_reset_ff(dll_rst), .o_dll_locked_ff(locked),
    .o_int_start_ff(start), .o_beat_vld_ff(vld), .o_beat_wr_ff(bwr),
    .o_dq_oe_ff(oe), .o_col_ff(col), .o_busy_ff(busy));
  dmrz_ctrl_model ctrl (.i_clk(clk), .i_busy(busy), .i_locked(locked), .o_cke(cke),
    .o_cs_n(cs_n), .o_ras_n(ras_n), .o_cas_n(cas_n), .o_we_n(we_n), .o_ba(ba),
    .o_addr(addr));

  always #2 clk = ~clk;

  task chk(input string nm, input [18:0] e, input [18:0] g);
    begin
      n_checks = n_checks + 1;
      if (e !== g) begin
        num_errors = num_errors + 1;
        $display("unexpected %s exp %0h got %0h", nm, e, g);
      end
    end
  endtask

  task summarize;
    begin
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
        $display("[ PASS ]");
      end else begin
        $display("[ FAIL ]");
      end
      $finish;
    end
  endtask

  // A hung handshake would otherwise stall forever; the run needs far fewer cycles.
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      summarize;
    end
  end

  // Beats are matched in order; latency counts from the start pulse.
  always @(posedge clk) begin
    cnt = cnt + 1;
    if (start) begin
      cnt = 0;
      first = 1'b1;
    end
    if (vld) begin
      if (exp_col.size() == 0) begin
        chk("extra beat", 0, 1);
      end else begin
        if (first) chk("latency", exp_lat.pop_front(), cnt);
        first = 1'b0;
        chk("column", exp_col.pop_front(), col);
        chk("write beat", exp_wr.pop_front(), bwr);
        chk("busy", 1, busy);
      end
    end
  end

  // Every latency code and recovery code, each load followed by a read and a write.
  initial begin
    void'($urandom(28));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (t = 0; t < 10; t = t + 1) begin
      cl = 5 + t;
      m = t % 6;
      // Recovery time in ns with a ragged tail; four ns a cycle, rounded up.
      twr_ns = 4 * ((m < 4) ? 5 + m : 2 * m + 2) - t % 4;
      wr = (twr_ns + 3) / 4;
      a = $urandom;
      a[1:0] = t % 3;
      {a[6:4], a[2]} = {cl[2:0] - 3'h4, cl > 11};
      a[11:9] = (wr < 9) ? wr - 4 : wr / 2;
      a[8] = (t == 3);
      bt = a[3];
      ctrl.cmd(4'h0, a);
      chk("mode", {3'h0, a & 16'h1e7f}, mode);
      chk("cas latency", cl, cl_o);
      chk("write recovery", wr, wr_o);
      chk("power-down dll", a[12], ppd);
      chk("config error", 0, err);
      for (k = 0; k < 2; k = k + 1) begin
        a = $urandom;
        st = a[2:0];
        chop = (t % 3 == 2) || (t % 3 == 1 && !a[12]);
        for (i = 0; i < (chop ? 4 : 8); i = i + 1) begin
          exp_wr.push_back(k);
          if (k) exp_col.push_back(chop ? {st[2], i[1:0]} : i[2:0]);
          else exp_col.push_back(bt ? st ^ i[2:0] : {st[2] ^ i[2], st[1:0] + i[1:0]});
        end
        exp_lat.push_back(k ? 1 : cl);
        ctrl.cmd(k ? 4'h4 : 4'h5, a);
        @(posedge clk);
        chk("beats left", 0, exp_col.size());
      end
      $display("test %0d done", t);
    end
    // Reserved burst, latency and recovery codes must raise the error flag.
    ctrl.cmd(4'h0, 16'h0003);
    chk("reserved error", 1, err);
    chk("reserved latency", 0, cl_o);
    chk("reserved recovery", 0, wr_o);
    $display("test reserved done");
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk("mode after reset", 0, mode);
    $display("test reset done");
    summarize;
  end
endmodule
